// ---- hw/deser_config_regs_low.sv ----
// Low configuration register bank of the deserializer with pin overrides
`timescale 1ns/1ps
// Overview of operation
// - Register 0x00 bits 7:1 hold a host read/write seven-bit target address.
// - Register 0x00 bit 0 set selects the programmed address, clear selects the strap address.
// - Register 0x01 bit 7 set powers the device down while no forward link is detected.
// - Register 0x01 bit 2 enables the reverse channel.
// - Writing 1 to register 0x01 bit 1 resets all logic and all registers, then clears itself.
// - Writing 1 to register 0x01 bit 0 resets all logic but keeps registers, then clears itself.
// - Register 0x02 bit 7 drives the parallel outputs, clear leaves them high impedance.
// - Register 0x02 bit 6 makes the register output-enable and idle-state bits replace the pins.
// - Register 0x02 bit 5 with lock lost puts the internal oscillator clock on the pixel clock.
// - Register 0x02 bit 4 selects the output state applied while lock is low.
// - Register 0x02 bit 3 makes compatibility mode follow bit 2 instead of the mode strap.
// - Under that override, bit 2 set turns compatibility mode on and clear turns it off.
// - Register 0x02 bit 1 takes the low-frequency range from bit 0 instead of its strap.
// - Low-frequency range set means a 5 to 15 MHz pixel clock, clear means 15 to 85 MHz.
// - The strap address is 0x2c plus a four-bit strap code, giving 0x2c to 0x3b.
module deser_config_regs_low
  import deser_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic [3:0] address_strap_pin,
  input wire logic pad_drive_pin,
  input wire logic idle_state_pin,
  input wire logic compat_mode_pin,
  input wire logic low_freq_pin,
  input wire logic lock,
  input wire logic forward_link_detected,
  output logic [6:0] target_address,
  output logic power_down,
  output logic reverse_channel_enable,
  output logic logic_reset,
  output logic output_drive_enable,
  output logic idle_output_state_select,
  output logic osc_clock_select,
  output logic compat_mode,
  output logic low_freq_range
);
  logic [7:0] target_cfg_reg;
  logic [7:0] power_ctrl_reg;
  logic [7:0] output_cfg_reg;
  logic full_reset_pending_reg;
  logic [7:0] rd_data_next;

  wire wr_target = wr_en && (reg_addr == addr_target_cfg);
  wire wr_power = wr_en && (reg_addr == addr_power_ctrl);
  wire wr_output = wr_en && (reg_addr == addr_output_cfg);
  // Reset request strobes taken straight from the write data
  wire full_reset_req = wr_power && wr_data[full_soft_reset_bit];
  wire logic_reset_req = wr_power && wr_data[logic_soft_reset_bit];
  wire [6:0] strap_addr = strap_addr_base + {3'h0, address_strap_pin};
  wire [6:0] addr_next = target_cfg_reg[target_addr_override_bit] ?
    target_cfg_reg[7:target_addr_lsb] : strap_addr;
  wire ovr = output_cfg_reg[pin_override_bit];
  wire drive_next = ovr ? output_cfg_reg[output_enable_bit] : pad_drive_pin;
  wire idle_next = ovr ? output_cfg_reg[idle_output_state_select_bit] : idle_state_pin;
  wire osc_next = output_cfg_reg[osc_clock_enable_bit] && !lock;
  wire compat_next = output_cfg_reg[compat_override_bit] ?
    output_cfg_reg[compat_select_bit] : compat_mode_pin;
  wire lf_next = output_cfg_reg[low_freq_override_bit] ?
    output_cfg_reg[low_freq_range_bit] : low_freq_pin;
  wire pd_next = power_ctrl_reg[auto_power_down_bit] && !forward_link_detected;

  // Reset bits are never stored, so reads show them as zero
  always_comb begin
    rd_data_next = 8'h00;
    if (reg_addr == addr_target_cfg) begin
      rd_data_next = target_cfg_reg;
    end else if (reg_addr == addr_power_ctrl) begin
      rd_data_next = power_ctrl_reg & power_ctrl_rw_mask;
    end else if (reg_addr == addr_output_cfg) begin
      rd_data_next = output_cfg_reg;
    end
  end

  // Full reset applied one cycle after its write so the write itself completes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      full_reset_pending_reg <= 1'b0;
    end else begin
      full_reset_pending_reg <= full_reset_req;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      target_cfg_reg <= target_cfg_reset;
      power_ctrl_reg <= power_ctrl_reset;
      output_cfg_reg <= output_cfg_reset;
    end else if (full_reset_pending_reg) begin
      target_cfg_reg <= target_cfg_reset;
      power_ctrl_reg <= power_ctrl_reset;
      output_cfg_reg <= output_cfg_reset;
    end else begin
      if (wr_target) begin
        target_cfg_reg <= wr_data;
      end
      if (wr_power) begin
        power_ctrl_reg <= wr_data & power_ctrl_rw_mask;
      end
      if (wr_output) begin
        output_cfg_reg <= wr_data;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
      target_address <= strap_addr_base;
      power_down <= 1'b0;
      reverse_channel_enable <= 1'b1;
      logic_reset <= 1'b0;
      output_drive_enable <= 1'b0;
      idle_output_state_select <= 1'b0;
      osc_clock_select <= 1'b0;
      compat_mode <= 1'b0;
      low_freq_range <= 1'b0;
    end else begin
      if (rd_en) begin
        rd_data <= rd_data_next;
      end
      target_address <= addr_next;
      power_down <= pd_next;
      reverse_channel_enable <= power_ctrl_reg[reverse_channel_enable_bit];
      logic_reset <= logic_reset_req || full_reset_req;
      output_drive_enable <= drive_next;
      idle_output_state_select <= idle_next;
      osc_clock_select <= osc_next;
      compat_mode <= compat_next;
      low_freq_range <= lf_next;
    end
  end
endmodule

// ---- shared/deser_cfg_pkg.sv ----
// Offsets, field positions and reset values of the low configuration registers
package deser_cfg_pkg;
  localparam logic [7:0] addr_target_cfg = 8'h00;
  localparam logic [7:0] addr_power_ctrl = 8'h01;
  localparam logic [7:0] addr_output_cfg = 8'h02;
  localparam int target_addr_lsb = 1;
  localparam int target_addr_override_bit = 0;
  localparam int auto_power_down_bit = 7;
  localparam int reverse_channel_enable_bit = 2;
  localparam int full_soft_reset_bit = 1;
  localparam int logic_soft_reset_bit = 0;
  localparam int output_enable_bit = 7;
  localparam int pin_override_bit = 6;
  localparam int osc_clock_enable_bit = 5;
  localparam int idle_output_state_select_bit = 4;
  localparam int compat_override_bit = 3;
  localparam int compat_select_bit = 2;
  localparam int low_freq_override_bit = 1;
  localparam int low_freq_range_bit = 0;
  localparam logic [7:0] target_cfg_reset = 8'h00;
  localparam logic [7:0] power_ctrl_reset = 8'h04;
  localparam logic [7:0] output_cfg_reset = 8'h00;
  localparam logic [7:0] power_ctrl_rw_mask = 8'h84;
  localparam logic [6:0] strap_addr_base = 7'h2c;
endpackage

// ---- dv/deser_cfg_assertions.sv ----
// Port checks for the low config registers
`timescale 1ns/1ps
module deser_cfg_checker import deser_cfg_pkg::*; (
  input wire logic ref_clk, rst_n, wr_en, rd_en, lock, forward_link_detected, logic_reset,
  input wire logic power_down, osc_clock_select, output_drive_enable, compat_mode,
  input wire logic [7:0] reg_addr, wr_data, rd_data,
  input wire logic [6:0] target_address,
  input wire logic [3:0] address_strap_pin);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic w0 = wr_en && reg_addr == 8'h00;
  wire logic w2 = wr_en && reg_addr == 8'h02;
  AST_TA: assert property (w0 && wr_data[0] |-> ##2
    target_address == $past(wr_data[7:1], 2)) else $error("address");
  AST_TS: assert property (w0 && !wr_data[0] |-> ##2
    target_address == strap_addr_base + $past(address_strap_pin)) else $error("strap");
  AST_PD: assert property (forward_link_detected |=> !power_down) else $error("power");
  AST_OSC: assert property (lock |=> !osc_clock_select) else $error("osc");
  AST_LR: assert property (wr_en && reg_addr == 8'h01 && |wr_data[1:0] |=> logic_reset)
    else $error("reset");
  AST_OE: assert property (w2 && wr_data[6] |-> ##2
    output_drive_enable == $past(wr_data[7], 2)) else $error("drive");
  AST_CM: assert property (w2 && wr_data[3] |-> ##2
    compat_mode == $past(wr_data[2], 2)) else $error("compat");
  AST_RD: assert property (rd_en && reg_addr == 8'h01 |=> (rd_data & 8'h7b) == 8'h00)
    else $error("reserved");
endmodule
bind deser_config_regs_low deser_cfg_checker deser_cfg_checker_inst (.*);

// ---- dv/host.sv ----
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
module host (
  input wire logic ref_clk,
  output logic wr_en = 1'b0, rd_en = 1'b0,
  output logic [7:0] reg_addr = 8'h00, wr_data = 8'h00);
  task access(input logic w, input logic [7:0] a, d);
    @(posedge ref_clk); wr_en <= w; rd_en <= !w; reg_addr <= a; wr_data <= d;
    // Released fields go inverted so stale data never looks live
    @(posedge ref_clk); wr_en <= 1'b0; rd_en <= 1'b0; reg_addr <= ~a; wr_data <= ~d;
  endtask
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the low config registers
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0, rst_n = 1'b0, wr_en, rd_en, power_down, reverse_channel_enable;
  logic lock, forward_link_detected, pad_drive_pin, idle_state_pin, compat_mode_pin, low_freq_pin;
  logic logic_reset, output_drive_enable, idle_output_state_select, osc_clock_select;
  logic compat_mode, low_freq_range;
  logic [7:0] reg_addr, wr_data, rd_data;
  logic [6:0] target_address;
  logic [5:0] pv = 6'h00;
  logic [3:0] address_strap_pin = 4'h5;
  int bad_count = 0, total_checks = 0;
  assign {lock, forward_link_detected, pad_drive_pin, idle_state_pin, compat_mode_pin,
    low_freq_pin} = pv;
  wire logic [7:0] ta = {1'b0, target_address}, outs = {power_down, reverse_channel_enable,
    logic_reset, output_drive_enable, idle_output_state_select, osc_clock_select, compat_mode,
    low_freq_range};
  always #2.5 ref_clk = ~ref_clk;
  deser_config_regs_low deser_config_regs_low_inst (.*);
  host host_inst (.*);
  task chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin bad_count++; $display("BAD %0t %h %h", $time, got, exp); end
  endtask
  task summarize;
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, d); host_inst.access(1'b1, a, d); endtask
  task rd(input logic [7:0] a, e); host_inst.access(1'b0, a, 8'h00); #1 chk(rd_data, e); endtask
  task settle; repeat (2) @(posedge ref_clk); #1; endtask
  task pins(input logic [5:0] v); @(posedge ref_clk); pv <= v; settle; endtask
  task pulse; #1 chk(outs & 8'h20, 8'h20);
    @(posedge ref_clk); #1 chk(outs & 8'h20, 8'h00); endtask
  task defaults;
    rd(8'h00, 8'h00); rd(8'h01, 8'h04); rd(8'h02, 8'h00); rd(8'h09, 8'h00);
    chk(ta, 8'h31); chk(outs, 8'h40);
  endtask
  task addressing;
    wr(8'h00, 8'h5b); rd(8'h00, 8'h5b); chk(ta, 8'h2d);
    wr(8'h00, 8'h5a); settle; chk(ta, 8'h31);
    // Top strap code checks the upper end of the strap address range
    @(posedge ref_clk); address_strap_pin <= 4'hf; settle; chk(ta, 8'h3b);
  endtask
  task power;
    wr(8'h01, 8'hf8); rd(8'h01, 8'h80); chk(outs, 8'h80);
    pins(6'h10); chk(outs, 8'h00); wr(8'h01, 8'h04);
  endtask
  task outputs;
    wr(8'h02, 8'hfe); settle; chk(outs, 8'h5e); pins(6'h3f); chk(outs, 8'h5a);
    wr(8'h02, 8'h01); settle; chk(outs, 8'h5b); pins(6'h10); chk(outs, 8'h40);
    wr(8'h02, 8'h03); settle; chk(outs, 8'h41);
  endtask
  task resets;
    wr(8'h02, 8'hd5); wr(8'h01, 8'h05); pulse; rd(8'h02, 8'hd5);
    wr(8'h01, 8'h02); pulse; rd(8'h02, 8'h00); rd(8'h00, 8'h00); rd(8'h01, 8'h04);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    defaults; addressing; power; outputs; resets; summarize;
  end
  initial begin #100000; bad_count++; summarize; end
endmodule
